// [rtl/bsl_pkg.sv]
// Package: register map, field layout, limits, timing and mode codes of the supervisor
package bsl_pkg;

    // Clock and the common 10 ms timing tick
    localparam int CLK_NS      = 40;
    localparam int TICK_MS     = 10;
    localparam int TICK_NS     = TICK_MS * 1000000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

    // Bus and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int CUR_W  = 16;

    // Register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_UC_LEVEL  = 8'h04;
    localparam logic [7:0] REG_UC_DELAY  = 8'h08;
    localparam logic [7:0] REG_BF_LEVEL  = 8'h0C;
    localparam logic [7:0] REG_BF_DELAY  = 8'h10;
    localparam logic [7:0] REG_TCS_DELAY = 8'h14;
    localparam logic [7:0] REG_STATUS    = 8'h18;
    localparam logic [7:0] REG_COMMAND   = 8'h1C;

    // Control register fields
    localparam int CTRL_UC_LSB  = 0;
    localparam int CTRL_BF_LSB  = 4;
    localparam int CTRL_TCS_LSB = 8;
    localparam int CTRL_REL_BIT = 12;

    // Status register bits
    localparam int ST_UC_TIMED  = 0;
    localparam int ST_UC_LATCH  = 1;
    localparam int ST_BF_TIMING = 2;
    localparam int ST_BF_OUT    = 3;
    localparam int ST_TCS_ALARM = 4;
    localparam int ST_TRIP_FLAG = 5;
    localparam int ST_TRIP_OUT  = 6;
    localparam int ST_ALARM_OUT = 7;

    // Command register bits
    localparam int CMD_RESET_BIT = 0;

    // Times in ms as set, and their counts in ticks
    localparam int UC_DELAY_MAX_MS  = 200000;
    localparam int BF_DELAY_MIN_MS  = 10;
    localparam int BF_DELAY_MAX_MS  = 10000;
    localparam int TCS_DELAY_MIN_MS = 100;
    localparam int TCS_DELAY_MAX_MS = 10000;
    localparam int TRIP_PULSE_MS    = 100;
    localparam logic [15:0] UC_DELAY_MAX   = 16'(UC_DELAY_MAX_MS / TICK_MS);
    localparam logic [15:0] BF_DELAY_MIN   = 16'(BF_DELAY_MIN_MS / TICK_MS);
    localparam logic [15:0] BF_DELAY_MAX   = 16'(BF_DELAY_MAX_MS / TICK_MS);
    localparam logic [15:0] TCS_DELAY_MIN  = 16'(TCS_DELAY_MIN_MS / TICK_MS);
    localparam logic [15:0] TCS_DELAY_MAX  = 16'(TCS_DELAY_MAX_MS / TICK_MS);
    localparam logic [15:0] TRIP_PULSE_TCK = 16'(TRIP_PULSE_MS / TICK_MS);

    // Current thresholds in percent of rated current
    localparam logic [15:0] LEVEL_MIN = 16'h000A;
    localparam logic [15:0] LEVEL_MAX = 16'h00C8;

    // Reset values
    localparam logic [15:0] UC_LEVEL_RST  = 16'h0014;
    localparam logic [15:0] UC_DELAY_RST  = 16'h0064;
    localparam logic [15:0] BF_LEVEL_RST  = 16'h0014;
    localparam logic [15:0] BF_DELAY_RST  = 16'h0010;
    localparam logic [15:0] TCS_DELAY_RST = 16'h0064;

    typedef enum logic [2:0] {
        UC_OFF          = 3'h0,
        UC_ALARM        = 3'h1,
        UC_TRIP         = 3'h2,
        UC_TRIP_INRUSH  = 3'h3,
        UC_TRIP_LATCH   = 3'h4,
        UC_ALARM_CLOSED = 3'h5,
        UC_TRIP_CLOSED  = 3'h6
    } bsl_uc_mode_t;

    typedef enum logic [1:0] {
        BF_DISABLED = 2'h0,
        BF_RETRIP   = 2'h1,
        BF_ALARM    = 2'h2
    } bsl_bf_mode_t;

    typedef enum logic [1:0] {
        TCS_OFF    = 2'h0,
        TCS_ALWAYS = 2'h1,
        TCS_CLOSED = 2'h2
    } bsl_tcs_mode_t;

    typedef enum logic [1:0] {
        BF_IDLE   = 2'h0,
        BF_TIMING = 2'h1,
        BF_FAILED = 2'h2
    } bsl_bf_state_t;

endpackage

// [rtl/bsl_timer.sv]
// Tick-driven delay timer: counts while run is high, clears when it drops
module bsl_timer #(
    parameter int W = 16
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic         tick_i,
    input  wire logic         run_i,
    input  wire logic [W-1:0] limit_i,
    output logic              done_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } bsl_tmr_t;

    bsl_tmr_t st_ff;
    bsl_tmr_t nxt_st;

    // Refuse widths the counter cannot serve
    if (W < 2)
    begin : g_chk
        $error("bsl_timer: W too small");
    end

    // Count saturates at the limit, so no wrap back to zero
    always_comb
    begin
        nxt_st = st_ff;
        if (!run_i)
        begin
            nxt_st.cnt = '0;
        end
        else if (tick_i && (st_ff.cnt < limit_i))
        begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
        nxt_st.done = run_i && (nxt_st.cnt >= limit_i);
    end

    // State register
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = st_ff.done;

endmodule

// [rtl/bsl_supervisor.sv]
// Breaker supervision: undercurrent stage, breaker-fail element, trip-circuit check
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
module bsl_supervisor #(
    parameter int TICK_CYCLES = bsl_pkg::TICK_CYCLES,
    parameter int TICK_W      = 18
) (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic [bsl_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [bsl_pkg::DATA_W-1:0] wr_data_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [bsl_pkg::DATA_W-1:0] rd_data_o,
    input  wire logic [bsl_pkg::CUR_W-1:0]  phase_a_i,
    input  wire logic [bsl_pkg::CUR_W-1:0]  phase_b_i,
    input  wire logic [bsl_pkg::CUR_W-1:0]  phase_c_i,
    input  wire logic                       prot_trip_cmd_i,
    input  wire logic                       aux_trip_i,
    input  wire logic                       inrush_block_i,
    input  wire logic                       breaker_open_status_input_i,
    input  wire logic                       breaker_closed_i,
    input  wire logic                       trip_circuit_check_i,
    input  wire logic                       manual_breaker_open_command_i,
    input  wire logic                       reset_input_i,
    input  wire logic                       reset_local_i,
    output logic                            undercurrent_timed_output_o,
    output logic                            prot_trip_o,
    output logic                            trip_pulse_o,
    output logic                            alarm_o,
    output logic                            trip_led_o,
    output logic                            alarm_led_o,
    output logic                            breaker_fail_output_o,
    output logic                            release_blocking_o,
    output logic                            tcs_alarm_o
);

    typedef struct packed {
        logic [TICK_W-1:0]              tick_cnt;
        logic                           tick;
        bsl_pkg::bsl_uc_mode_t          uc_mode;
        bsl_pkg::bsl_bf_mode_t          bf_mode;
        bsl_pkg::bsl_tcs_mode_t         tcs_mode;
        logic                           release_en;
        logic [bsl_pkg::REG_W-1:0]      uc_level;
        logic [bsl_pkg::REG_W-1:0]      uc_delay;
        logic [bsl_pkg::REG_W-1:0]      bf_level;
        logic [bsl_pkg::REG_W-1:0]      bf_delay;
        logic [bsl_pkg::REG_W-1:0]      tcs_delay;
        bsl_pkg::bsl_bf_state_t         bf_state;
        logic                           trig_prev;
        logic                           uc_latch;
        logic                           trip_flag;
        logic                           alarm_led;
        logic                           uc_timed;
        logic                           prot_trip;
        logic                           trip_pulse;
        logic                           alarm;
        logic                           bf_out;
        logic                           release_blk;
        logic                           tcs_alarm;
        logic [bsl_pkg::DATA_W-1:0]     rd_data;
    } bsl_state_t;

    localparam bsl_state_t RST_STATE = '{
        uc_mode:   bsl_pkg::UC_OFF,
        bf_mode:   bsl_pkg::BF_DISABLED,
        tcs_mode:  bsl_pkg::TCS_OFF,
        uc_level:  bsl_pkg::UC_LEVEL_RST,
        uc_delay:  bsl_pkg::UC_DELAY_RST,
        bf_level:  bsl_pkg::BF_LEVEL_RST,
        bf_delay:  bsl_pkg::BF_DELAY_RST,
        tcs_delay: bsl_pkg::TCS_DELAY_RST,
        bf_state:  bsl_pkg::BF_IDLE,
        default:   '0
    };

    bsl_state_t st_ff;
    bsl_state_t nxt_st;

    logic uc_done;
    logic bf_done;
    logic tcs_done;
    logic pulse_done;
    logic uc_below;
    logic uc_block;
    logic uc_run;
    logic bf_current;
    logic bf_run;
    logic tcs_watch;
    logic tcs_run;
    logic rst_cmd;
    logic uc_trip_mode;
    logic uc_alarm_mode;

    // Refuse tick settings the divider cannot hold
    if ((TICK_CYCLES < 1) || (TICK_CYCLES > (2 ** TICK_W)))
    begin : g_chk
        $error("bsl_supervisor: TICK_CYCLES out of range for TICK_W");
    end

    // Keep a written value inside its legal range
    function automatic logic [15:0] bsl_clamp(
        input logic [15:0] val,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        logic [15:0] res;
        res = val;
        if (val < lo)
        begin
            res = lo;
        end
        else if (val > hi)
        begin
            res = hi;
        end
        return res;
    endfunction

    // Any of the three reset sources clears latched indications
    assign rst_cmd = reset_input_i || reset_local_i
                     || (wr_i && (addr_i == bsl_pkg::REG_COMMAND)
                         && wr_data_i[bsl_pkg::CMD_RESET_BIT]);

    // Undercurrent pickup: all phases below the general threshold
    assign uc_below = (phase_a_i < st_ff.uc_level)
                      && (phase_b_i < st_ff.uc_level)
                      && (phase_c_i < st_ff.uc_level);

    // Mode dependent blocking of the general stage
    always_comb
    begin
        case (st_ff.uc_mode)
            bsl_pkg::UC_ALARM,
            bsl_pkg::UC_TRIP,
            bsl_pkg::UC_TRIP_LATCH:   uc_block = 1'b0;
            bsl_pkg::UC_TRIP_INRUSH:  uc_block = inrush_block_i;
            bsl_pkg::UC_ALARM_CLOSED,
            bsl_pkg::UC_TRIP_CLOSED:  uc_block = breaker_open_status_input_i;
            default:                  uc_block = 1'b1;
        endcase
    end

    // Which modes feed the trip path and which the alarm path
    assign uc_alarm_mode = (st_ff.uc_mode == bsl_pkg::UC_ALARM)
                           || (st_ff.uc_mode == bsl_pkg::UC_ALARM_CLOSED);
    assign uc_trip_mode  = !uc_alarm_mode && !uc_block
                           && (st_ff.uc_mode != bsl_pkg::UC_OFF);

    assign uc_run = !uc_block && uc_below;

    // Breaker-fail: any single phase above its band means a pole still carries
    assign bf_current = (phase_a_i >= st_ff.bf_level)
                        || (phase_b_i >= st_ff.bf_level)
                        || (phase_c_i >= st_ff.bf_level);
    assign bf_run = (st_ff.bf_state == bsl_pkg::BF_TIMING) && bf_current;

    // Trip-circuit watch window; trip pulse and manual open would read as loss
    always_comb
    begin
        case (st_ff.tcs_mode)
            bsl_pkg::TCS_ALWAYS: tcs_watch = 1'b1;
            bsl_pkg::TCS_CLOSED: tcs_watch = breaker_closed_i;
            default:             tcs_watch = 1'b0;
        endcase
    end
    assign tcs_run = tcs_watch && !st_ff.trip_pulse && !prot_trip_cmd_i
                     && !manual_breaker_open_command_i
                     && !trip_circuit_check_i;

    // Delay timers, all stepped by the 10 ms tick
    bsl_timer #(
        .W (bsl_pkg::REG_W)
    ) u_uc_timer (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_i  (st_ff.tick),
        .run_i   (uc_run),
        .limit_i (st_ff.uc_delay),
        .done_o  (uc_done)
    );

    bsl_timer #(
        .W (bsl_pkg::REG_W)
    ) u_bf_timer (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_i  (st_ff.tick),
        .run_i   (bf_run),
        .limit_i (st_ff.bf_delay),
        .done_o  (bf_done)
    );

    bsl_timer #(
        .W (bsl_pkg::REG_W)
    ) u_tcs_timer (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_i  (st_ff.tick),
        .run_i   (tcs_run),
        .limit_i (st_ff.tcs_delay),
        .done_o  (tcs_done)
    );

    bsl_timer #(
        .W (bsl_pkg::REG_W)
    ) u_pulse_timer (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .tick_i  (st_ff.tick),
        .run_i   (st_ff.trip_pulse),
        .limit_i (bsl_pkg::TRIP_PULSE_TCK),
        .done_o  (pulse_done)
    );

    // Next state: divider, register writes, protection logic, read data
    always_comb
    begin
        logic uc_trip;
        logic trig;
        logic bf_fail;
        logic retrip;
        logic bf_alarm;
        uc_trip  = 1'b0;
        trig     = 1'b0;
        bf_fail  = 1'b0;
        retrip   = 1'b0;
        bf_alarm = 1'b0;
        nxt_st   = st_ff;

        // Tick divider
        if (st_ff.tick_cnt == TICK_W'(TICK_CYCLES - 1))
        begin
            nxt_st.tick_cnt = '0;
            nxt_st.tick     = 1'b1;
        end
        else
        begin
            nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
            nxt_st.tick     = 1'b0;
        end

        // Register writes; out of range levels and delays are clamped
        if (wr_i)
        begin
            case (addr_i)
                bsl_pkg::REG_CTRL:
                begin
                    nxt_st.uc_mode    = bsl_pkg::bsl_uc_mode_t'(
                                        wr_data_i[bsl_pkg::CTRL_UC_LSB +: 3]);
                    nxt_st.bf_mode    = bsl_pkg::bsl_bf_mode_t'(
                                        wr_data_i[bsl_pkg::CTRL_BF_LSB +: 2]);
                    nxt_st.tcs_mode   = bsl_pkg::bsl_tcs_mode_t'(
                                        wr_data_i[bsl_pkg::CTRL_TCS_LSB +: 2]);
                    nxt_st.release_en = wr_data_i[bsl_pkg::CTRL_REL_BIT];
                end
                bsl_pkg::REG_UC_LEVEL:  nxt_st.uc_level  = bsl_clamp(wr_data_i[15:0],
                                            bsl_pkg::LEVEL_MIN, bsl_pkg::LEVEL_MAX);
                bsl_pkg::REG_UC_DELAY:  nxt_st.uc_delay  = bsl_clamp(wr_data_i[15:0],
                                            16'h0000, bsl_pkg::UC_DELAY_MAX);
                bsl_pkg::REG_BF_LEVEL:  nxt_st.bf_level  = bsl_clamp(wr_data_i[15:0],
                                            bsl_pkg::LEVEL_MIN, bsl_pkg::LEVEL_MAX);
                bsl_pkg::REG_BF_DELAY:  nxt_st.bf_delay  = bsl_clamp(wr_data_i[15:0],
                                            bsl_pkg::BF_DELAY_MIN, bsl_pkg::BF_DELAY_MAX);
                bsl_pkg::REG_TCS_DELAY: nxt_st.tcs_delay = bsl_clamp(wr_data_i[15:0],
                                            bsl_pkg::TCS_DELAY_MIN, bsl_pkg::TCS_DELAY_MAX);
                default: ;
            endcase
        end

        // Latched trip: a new trip wins over a reset in the same cycle
        nxt_st.uc_latch = ((st_ff.uc_mode == bsl_pkg::UC_TRIP_LATCH) && uc_done)
                          || (st_ff.uc_latch && !rst_cmd);
        uc_trip = (uc_trip_mode && uc_done) || st_ff.uc_latch;

        // Breaker-fail start on the leading edge of any trip command
        trig = prot_trip_cmd_i || aux_trip_i || uc_trip;
        nxt_st.trig_prev = trig;

        case (st_ff.bf_state)
            bsl_pkg::BF_IDLE:
            begin
                if ((st_ff.bf_mode == bsl_pkg::BF_RETRIP
                     || st_ff.bf_mode == bsl_pkg::BF_ALARM)
                    && trig && !st_ff.trig_prev && bf_current)
                begin
                    nxt_st.bf_state = bsl_pkg::BF_TIMING;
                end
            end
            bsl_pkg::BF_TIMING:
            begin
                if (!bf_current || st_ff.bf_mode == bsl_pkg::BF_DISABLED)
                begin
                    nxt_st.bf_state = bsl_pkg::BF_IDLE;
                end
                else if (bf_done)
                begin
                    nxt_st.bf_state = bsl_pkg::BF_FAILED;
                end
            end
            bsl_pkg::BF_FAILED:
            begin
                // Held while the fault current persists
                if (!bf_current || st_ff.bf_mode == bsl_pkg::BF_DISABLED)
                begin
                    nxt_st.bf_state = bsl_pkg::BF_IDLE;
                end
            end
            default: nxt_st.bf_state = bsl_pkg::BF_IDLE;
        endcase

        bf_fail  = st_ff.bf_state == bsl_pkg::BF_FAILED;
        retrip   = bf_fail && (st_ff.bf_mode == bsl_pkg::BF_RETRIP);
        bf_alarm = bf_fail && (st_ff.bf_mode == bsl_pkg::BF_ALARM);

        // Output stage
        nxt_st.bf_out      = bf_fail;
        nxt_st.release_blk = bf_fail && st_ff.release_en;
        nxt_st.uc_timed    = uc_done;
        nxt_st.prot_trip   = uc_trip || retrip;
        nxt_st.tcs_alarm   = tcs_done;
        nxt_st.alarm       = (uc_alarm_mode && !uc_block && uc_done)
                             || bf_alarm || st_ff.tcs_alarm;

        // Trip pulse of fixed length on each new trip
        nxt_st.trip_pulse = (nxt_st.prot_trip && !st_ff.prot_trip)
                            || (st_ff.trip_pulse && !pulse_done);

        // Indicators: setting wins over a clear in the same cycle
        nxt_st.trip_flag = nxt_st.prot_trip || (st_ff.trip_flag && !rst_cmd);
        nxt_st.alarm_led = nxt_st.alarm || (st_ff.alarm_led && !rst_cmd);

        // Read data stand only in the cycle after the strobe
        nxt_st.rd_data = '0;
        if (rd_i)
        begin
            case (addr_i)
                bsl_pkg::REG_CTRL:
                begin
                    nxt_st.rd_data[bsl_pkg::CTRL_UC_LSB +: 3]  = st_ff.uc_mode;
                    nxt_st.rd_data[bsl_pkg::CTRL_BF_LSB +: 2]  = st_ff.bf_mode;
                    nxt_st.rd_data[bsl_pkg::CTRL_TCS_LSB +: 2] = st_ff.tcs_mode;
                    nxt_st.rd_data[bsl_pkg::CTRL_REL_BIT]      = st_ff.release_en;
                end
                bsl_pkg::REG_UC_LEVEL:  nxt_st.rd_data[15:0] = st_ff.uc_level;
                bsl_pkg::REG_UC_DELAY:  nxt_st.rd_data[15:0] = st_ff.uc_delay;
                bsl_pkg::REG_BF_LEVEL:  nxt_st.rd_data[15:0] = st_ff.bf_level;
                bsl_pkg::REG_BF_DELAY:  nxt_st.rd_data[15:0] = st_ff.bf_delay;
                bsl_pkg::REG_TCS_DELAY: nxt_st.rd_data[15:0] = st_ff.tcs_delay;
                bsl_pkg::REG_STATUS:
                begin
                    nxt_st.rd_data[bsl_pkg::ST_UC_TIMED]  = st_ff.uc_timed;
                    nxt_st.rd_data[bsl_pkg::ST_UC_LATCH]  = st_ff.uc_latch;
                    nxt_st.rd_data[bsl_pkg::ST_BF_TIMING] =
                        st_ff.bf_state == bsl_pkg::BF_TIMING;
                    nxt_st.rd_data[bsl_pkg::ST_BF_OUT]    = st_ff.bf_out;
                    nxt_st.rd_data[bsl_pkg::ST_TCS_ALARM] = st_ff.tcs_alarm;
                    nxt_st.rd_data[bsl_pkg::ST_TRIP_FLAG] = st_ff.trip_flag;
                    nxt_st.rd_data[bsl_pkg::ST_TRIP_OUT]  = st_ff.prot_trip;
                    nxt_st.rd_data[bsl_pkg::ST_ALARM_OUT] = st_ff.alarm;
                end
                default: nxt_st.rd_data = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= RST_STATE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign rd_data_o                   = st_ff.rd_data;
    assign undercurrent_timed_output_o = st_ff.uc_timed;
    assign prot_trip_o                 = st_ff.prot_trip;
    assign trip_pulse_o                = st_ff.trip_pulse;
    assign alarm_o                     = st_ff.alarm;
    assign trip_led_o                  = st_ff.trip_flag;
    assign alarm_led_o                 = st_ff.alarm_led;
    assign breaker_fail_output_o       = st_ff.bf_out;
    assign release_blocking_o          = st_ff.release_blk;
    assign tcs_alarm_o                 = st_ff.tcs_alarm;

endmodule

// [dv/bsl_chk_assertions.sv]
// Checker: timing relations at the supervisor's ports
module bsl_chk (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic trip_circuit_check_i,
    input wire logic manual_breaker_open_command_i,
    input wire logic undercurrent_timed_output_o,
    input wire logic prot_trip_o,
    input wire logic trip_pulse_o,
    input wire logic alarm_o,
    input wire logic breaker_fail_output_o,
    input wire logic release_blocking_o,
    input wire logic tcs_alarm_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Voltage seen steadily; timer and output flops need a few cycles
    sequence s_volt;
        trip_circuit_check_i [*4];
    endsequence
    sequence s_loss;
        !$past(trip_circuit_check_i, 4) && !$past(trip_circuit_check_i, 8);
    endsequence
    chk_uc_route: assert property (undercurrent_timed_output_o |-> prot_trip_o || alarm_o)
        else $error("stage output not routed");
    chk_bf_route: assert property (breaker_fail_output_o |-> prot_trip_o || alarm_o)
        else $error("breaker fail not routed");
    chk_bf_retrip: assert property ($rose(breaker_fail_output_o) && prot_trip_o |-> trip_pulse_o)
        else $error("retrip without pulse");
    chk_release_bf: assert property (release_blocking_o |-> breaker_fail_output_o)
        else $error("release without breaker fail");
    chk_pulse_len: assert property ($rose(trip_pulse_o) |=> trip_pulse_o [*8])
        else $error("trip pulse too short");
    chk_tcs_clear: assert property (s_volt |=> !tcs_alarm_o)
        else $error("alarm with voltage present");
    chk_tcs_loss: assert property ($rose(tcs_alarm_o) |-> s_loss)
        else $error("alarm after broken loss");
    chk_tcs_hold: assert property ($rose(tcs_alarm_o) |-> !$past(manual_breaker_open_command_i, 4))
        else $error("alarm while suspended");
endmodule
bind bsl_supervisor bsl_chk bsl_chk_inst (.*);

// [dv/bsl_brk_model.sv]
// Breaker auxiliary contacts and trip circuit as the relay inputs see them
module bsl_brk_model (
    input  wire logic clock_i,
    input  wire logic open_i,
    input  wire logic cut_i,
    output logic      open_o,
    output logic      closed_o,
    output logic      volt_o
);
    logic pos_ff;
    // Contacts follow the poles one cycle late
    always_ff @(posedge clock_i)
    begin
        pos_ff <= open_i;
    end
    // Exactly one contact made; a cut circuit shows no voltage
    assign open_o   = pos_ff;
    assign closed_o = ~pos_ff;
    assign volt_o   = ~cut_i;
endmodule

// [dv/tb.sv]
// Self-checking bench for the breaker supervision block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 0, rst_n_i = 0, rd_seen = 0, bo, bc, volt, brk_open, cut;
    logic [7:0]  addr_i;
    logic [31:0] wr_data_i, rd_data_o, exp_q[$];
    logic [15:0] pa, pb, pc;
    logic        wr_i, rd_i, prot_trip_cmd_i, aux_trip_i, inrush_block_i, reset_input_i;
    logic        reset_local_i, manual_breaker_open_command_i, undercurrent_timed_output_o;
    logic        prot_trip_o, trip_pulse_o, alarm_o, trip_led_o, alarm_led_o;
    logic        breaker_fail_output_o, release_blocking_o, tcs_alarm_o;
    int          bad_count = 0, num_checks = 0;
    always #20 clock_i = ~clock_i;
    // Short tick keeps every delay to a few clocks
    bsl_supervisor #(.TICK_CYCLES(4)) bsl_supervisor_inst (.*, .phase_a_i(pa), .phase_b_i(pb),
        .phase_c_i(pc), .breaker_open_status_input_i(bo), .breaker_closed_i(bc),
        .trip_circuit_check_i(volt));
    bsl_brk_model bsl_brk_model_inst (.clock_i, .open_i(brk_open), .cut_i(cut), .open_o(bo),
        .closed_o(bc), .volt_o(volt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Bus cycles: strobe one cycle, always at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        if (!w)
            exp_q.push_back(d);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clock_i);
        {wr_i, rd_i} <= 2'b00;
    endtask
    task automatic put(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clock_i);
        {pa, pb, pc} <= {a, b, c};
    endtask
    // Cut the circuit long past the delay, then restore it
    task automatic tcs(input logic [31:0] ctl, input logic man, input logic op, input logic e);
        bus(1, 8'h00, ctl);
        manual_breaker_open_command_i <= man;
        brk_open <= op;
        cut <= 1'b1;
        wt(70);
        chk(tcs_alarm_o, e);
        @(posedge clock_i);
        cut <= 1'b0;
        wt(6);
        chk(tcs_alarm_o, 1'b0);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clock_i)
    begin
        if (rd_seen)
            chk(rd_data_o, exp_q.pop_front());
        rd_seen <= rd_i;
    end
    initial
    begin
        #400000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        {wr_i, rd_i, prot_trip_cmd_i, aux_trip_i, inrush_block_i, reset_input_i} = '0;
        {reset_local_i, manual_breaker_open_command_i, brk_open, cut, addr_i, wr_data_i} = '0;
        {pa, pb, pc} = {3{16'h0096}};
        void'($urandom(32'h4070));
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        bus(0, 8'h04, 32'h14);
        bus(0, 8'h20, 32'h0);
        bus(1, 8'h04, 32'h300);
        bus(0, 8'h04, 32'hC8);
        bus(1, 8'h04, 32'h5);
        bus(0, 8'h04, 32'hA);
        bus(1, 8'h04, 32'h64);
        bus(1, 8'h08, 32'h3);
        inrush_block_i <= 1'b1;
        brk_open <= 1'b1;
        // Every stage mode except UC_OFF with inrush block and open breaker present
        for (int m = 1; m < 7; m++)
        begin
            bus(1, 8'h00, 32'(m));
            put(16'($urandom_range(10, 99)), 16'h0032, 16'h0014);
            wt(6);
            chk(undercurrent_timed_output_o, 0);
            wt(18);
            chk(undercurrent_timed_output_o, m == 1 || m == 2 || m == 4);
            chk(prot_trip_o, m == 2 || m == 4);
            chk(alarm_o, m == 1);
            put(16'h0096, 16'h0096, 16'h0096);
            wt(4);
            chk(prot_trip_o, m == 4);
            reset_input_i <= 1'b1;
            @(posedge clock_i);
            reset_input_i <= 1'b0;
            wt(3);
            chk(prot_trip_o, 0);
        end
        {inrush_block_i, brk_open} <= 2'b00;
        bus(1, 8'h10, 32'h3);
        // Breaker fail modes; only one phase carries fault current
        for (int m = 0; m < 3; m++)
        begin
            bus(1, 8'h00, 32'(m << 4) | 32'h1000);
            put(16'h0005, 16'h0005, 16'h0096);
            aux_trip_i <= 1'b1;
            @(posedge clock_i);
            aux_trip_i <= 1'b0;
            wt(30);
            chk(breaker_fail_output_o, m != 0);
            chk(trip_pulse_o, m == 1);
            chk(alarm_led_o, m == 2);
            chk(release_blocking_o, m != 0);
            chk(trip_led_o, m == 1);
            put(16'h0005, 16'h0005, 16'h0005);
            wt(5);
            chk(breaker_fail_output_o, 0);
            reset_local_i <= 1'b1;
            @(posedge clock_i);
            reset_local_i <= 1'b0;
        end
        put(16'h0096, 16'h0005, 16'h0005);
        prot_trip_cmd_i <= 1'b1;
        wt(4);
        put(16'h0005, 16'h0005, 16'h0005);
        wt(30);
        chk(breaker_fail_output_o, 0);
        prot_trip_cmd_i <= 1'b0;
        bus(1, 8'h14, 32'hA);
        tcs(32'h100, 0, 0, 1);
        tcs(32'h100, 0, 1, 1);
        tcs(32'h200, 0, 1, 0);
        tcs(32'h200, 0, 0, 1);
        tcs(32'h100, 1, 0, 0);
        manual_breaker_open_command_i <= 1'b0;
        cut <= 1'b1;
        wt(30);
        chk(tcs_alarm_o, 0);
        cut <= 1'b0;
        @(posedge clock_i);
        cut <= 1'b1;
        wt(30);
        chk(tcs_alarm_o, 0);
        report_and_stop();
    end
endmodule
